/* hw/sbrg_dev.sv */
// serial clock generator: prescaler, baud rate generator and clock source selection
`timescale 1ns/100ps
`include "sbrg_defines.svh"
module sbrg_dev #(
  parameter int NCH = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  sbrg_if.dev       lnk
);

  typedef struct packed {
    logic [1:0]          pre4;
    logic [5:0]          pre;
    logic [NCH-1:0][7:0] divctl;
    logic [NCH-1:0][7:0] frac;
    logic [NCH-1:0][4:0] cnt;
    logic [NCH-1:0][3:0] acc;
    logic [NCH-1:0]      stretch;
    logic                half;
    logic [NCH-1:0]      ext_q;
    logic [NCH-1:0][3:0] ovs;
    logic [NCH-1:0]      sioclk;
    logic [NCH-1:0]      bit_tick;
    logic [NCH-1:0]      sclk;
    logic [NCH-1:0]      par;
    logic [NCH-1:0]      wak;
    logic [7:0]          rd_data;
  } sbrg_dev_s;

  sbrg_dev_s st_r;
  sbrg_dev_s st_nxt;

  // ==========================================================
  // next state
  always_comb
  begin
    logic       t4;
    logic [3:0] taps;
    logic       tap;
    logic [4:0] n_val;
    logic [3:0] n_code;
    logic [3:0] k_val;
    logic       frac_on;
    logic [4:0] period;
    logic [4:0] sum;
    logic       brg_tick;
    logic       ext_rise;
    logic       sio;
    logic       shift;
    t4       = 1'b0;
    taps     = 4'h0;
    tap      = 1'b0;
    n_val    = 5'h00;
    n_code   = 4'h0;
    k_val    = 4'h0;
    frac_on  = 1'b0;
    period   = 5'h00;
    sum      = 5'h00;
    brg_tick = 1'b0;
    ext_rise = 1'b0;
    sio      = 1'b0;
    shift    = 1'b0;
    st_nxt   = st_r;

    // prescaler runs on fc/4 and offers four taps
    st_nxt.pre4 = st_r.pre4 + 2'h1;
    t4          = (st_r.pre4 == `SBRG_PRE4_TOP);
    if (t4)
      st_nxt.pre = st_r.pre + 6'h01;
    taps[0] = t4;
    taps[1] = t4 && (st_r.pre[1:0] == 2'(`SBRG_PRE_TOP));
    taps[2] = t4 && (st_r.pre[3:0] == 4'(`SBRG_PRE_TOP));
    taps[3] = t4 && (st_r.pre == `SBRG_PRE_TOP);

    // internal clock at fc/2
    st_nxt.half = ~st_r.half;

    // register writes
    if (lnk.wr_en && lnk.wr_addr == `SBRG_ADDR_DIVCTL)
      st_nxt.divctl[lnk.wr_ch] = lnk.wr_data;
    if (lnk.wr_en && lnk.wr_addr == `SBRG_ADDR_FRAC)
      st_nxt.frac[lnk.wr_ch] = lnk.wr_data;

    // register read, answered one cycle after the request
    if (lnk.rd_addr == `SBRG_ADDR_DIVCTL)
      st_nxt.rd_data = st_r.divctl[lnk.rd_ch];
    else if (lnk.rd_addr == `SBRG_ADDR_FRAC)
      st_nxt.rd_data = st_r.frac[lnk.rd_ch];
    else
      st_nxt.rd_data = 8'h00;

    // identical generator per channel, each on its own registers
    for (int c = 0; c < NCH; c++)
    begin
      shift  = (lnk.mode[c] == sbrg_pkg::SBRG_MODE_SHIFT);
      tap    = taps[st_r.divctl[c][`SBRG_TAP_MSB:`SBRG_TAP_LSB]];
      n_code = st_r.divctl[c][`SBRG_DIV_MSB:`SBRG_DIV_LSB];
      n_val  = (n_code == 4'h0) ? `SBRG_N_CODE_ZERO : {1'b0, n_code};
      k_val  = st_r.frac[c][`SBRG_K_MSB:`SBRG_K_LSB];
      // fraction only with enable, K nonzero, N 2..15 and async mode
      frac_on = st_r.divctl[c][`SBRG_FEN_BIT] && (k_val != 4'h0) &&
                (n_code > 4'h1) && !shift;
      period  = n_val + {4'h0, st_r.stretch[c]};
      brg_tick = 1'b0;
      st_nxt.sioclk[c]   = 1'b0;
      st_nxt.bit_tick[c] = 1'b0;

      // divider counts selected tap pulses
      if (tap)
      begin
        if (st_r.cnt[c] + 5'h01 >= period)
        begin
          st_nxt.cnt[c] = 5'h00;
          brg_tick      = 1'b1;
          // accumulate 16-K per period; each carry stretches the next one
          sum = {1'b0, st_r.acc[c]} + (5'h10 - {1'b0, k_val});
          st_nxt.acc[c]     = frac_on ? sum[3:0] : 4'h0;
          st_nxt.stretch[c] = frac_on && sum[4];
        end
        else
          st_nxt.cnt[c] = st_r.cnt[c] + 5'h01;
      end

      // external clock edge, inputs already synchronous
      st_nxt.ext_q[c] = lnk.ext_clk[c];
      ext_rise        = lnk.ext_clk[c] && !st_r.ext_q[c];

      if (!shift)
      begin
        // async mode: pick basic clock, bit every 16 pulses
        case (lnk.src[c])
          sbrg_pkg::SBRG_SRC_BRG: sio = brg_tick;
          sbrg_pkg::SBRG_SRC_FC2: sio = st_r.half;
          sbrg_pkg::SBRG_SRC_TMR: sio = lnk.timer_match;
          sbrg_pkg::SBRG_SRC_EXT: sio = ext_rise;
          default:                sio = 1'b0;
        endcase
        st_nxt.sioclk[c] = sio;
        if (sio)
        begin
          st_nxt.ovs[c] = st_r.ovs[c] + 4'h1;
          st_nxt.bit_tick[c] = (st_r.ovs[c] == `SBRG_OVS_LAST);
        end
        st_nxt.sclk[c] = 1'b1;
      end
      else
      begin
        // shift mode: timer and fc/2 are not offered, generator is used instead
        st_nxt.ovs[c] = 4'h0;
        if (lnk.src[c] == sbrg_pkg::SBRG_SRC_EXT)
        begin
          st_nxt.sclk[c]     = lnk.ext_clk[c];
          st_nxt.sioclk[c]   = ext_rise;
          st_nxt.bit_tick[c] = ext_rise;
        end
        else if (brg_tick)
        begin
          // shift clock toggles per generator pulse: bit every two
          st_nxt.sclk[c]     = ~st_r.sclk[c];
          st_nxt.sioclk[c]   = 1'b1;
          st_nxt.bit_tick[c] = !st_r.sclk[c];
        end
      end

      // parity only in 7 and 8 bit formats, wake-up only in 9 bit
      st_nxt.par[c] = !shift && lnk.parity_req[c] &&
                      (lnk.fmt[c] == sbrg_pkg::SBRG_FMT_7B ||
                       lnk.fmt[c] == sbrg_pkg::SBRG_FMT_8B);
      st_nxt.wak[c] = !shift && (lnk.fmt[c] == sbrg_pkg::SBRG_FMT_9B);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r        <= '0;
      st_r.divctl <= {NCH{`SBRG_DIVCTL_RST}};
      st_r.frac   <= {NCH{`SBRG_FRAC_RST}};
      st_r.sclk   <= '1;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // link outputs, all from the state register
  assign lnk.rd_data   = st_r.rd_data;
  assign lnk.sioclk    = st_r.sioclk;
  assign lnk.bit_tick  = st_r.bit_tick;
  assign lnk.sclk      = st_r.sclk;
  assign lnk.parity_on = st_r.par;
  assign lnk.wakeup_on = st_r.wak;

endmodule

/* hw/sbrg_defines.svh */
// register offsets, field positions, reset values and counts of the baud rate generator
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH

// ==========================================================
// register offsets on the configuration port
`define SBRG_ADDR_DIVCTL   2'h0
`define SBRG_ADDR_FRAC     2'h1
`define SBRG_ADDR_MODE     2'h2

// ==========================================================
// baud_divider_control fields
`define SBRG_DIV_LSB       0
`define SBRG_DIV_MSB       3
`define SBRG_TAP_LSB       4
`define SBRG_TAP_MSB       5
`define SBRG_FEN_BIT       6
// baud_fraction_setting fields
`define SBRG_K_LSB         0
`define SBRG_K_MSB         3
// channel_mode_register fields
`define SBRG_SRC_LSB       0
`define SBRG_SRC_MSB       1
`define SBRG_FMT_LSB       2
`define SBRG_FMT_MSB       3
`define SBRG_SHIFT_BIT     4
`define SBRG_PAR_BIT       5

// ==========================================================
// reset values
`define SBRG_DIVCTL_RST    8'h00
`define SBRG_FRAC_RST      8'h00
`define SBRG_MODE_RST      8'h00

// ==========================================================
// division counts
`define SBRG_N_CODE_ZERO   5'h10
`define SBRG_OVS_LAST      4'hF
`define SBRG_PRE_TOP       6'h3F
`define SBRG_PRE4_TOP      2'h3

`endif

/* hw/sbrg_pkg.sv */
// types shared by both ends of the baud rate generator
package sbrg_pkg;

  // ==========================================================
  // basic clock source in asynchronous mode
  typedef enum logic [1:0] {
    SBRG_SRC_BRG,
    SBRG_SRC_FC2,
    SBRG_SRC_TMR,
    SBRG_SRC_EXT
  } sbrg_src_e;

  // asynchronous data formats
  typedef enum logic [1:0] {
    SBRG_FMT_7B,
    SBRG_FMT_8B,
    SBRG_FMT_9B,
    SBRG_FMT_RSV
  } sbrg_fmt_e;

  // channel operating mode
  typedef enum logic {
    SBRG_MODE_UART,
    SBRG_MODE_SHIFT
  } sbrg_mode_e;

endpackage

/* hw/sbrg_if.sv */
// link between the shift logic end and the clock generator end
`timescale 1ns/100ps
interface sbrg_if #(
  parameter int NCH = 2
);
  // ==========================================================
  // register access
  logic                  wr_en;
  logic                  wr_ch;
  logic [1:0]            wr_addr;
  logic [7:0]            wr_data;
  logic                  rd_ch;
  logic [1:0]            rd_addr;
  logic [7:0]            rd_data;
  // per channel settings and clock sources
  sbrg_pkg::sbrg_mode_e [NCH-1:0] mode;
  sbrg_pkg::sbrg_fmt_e  [NCH-1:0] fmt;
  sbrg_pkg::sbrg_src_e  [NCH-1:0] src;
  logic [NCH-1:0]        parity_req;
  logic [NCH-1:0]        ext_clk;
  logic                  timer_match;
  // generated clocks and format status
  logic [NCH-1:0]        sioclk;
  logic [NCH-1:0]        bit_tick;
  logic [NCH-1:0]        sclk;
  logic [NCH-1:0]        parity_on;
  logic [NCH-1:0]        wakeup_on;

  modport dev (
    input  wr_en, wr_ch, wr_addr, wr_data, rd_ch, rd_addr,
    input  mode, fmt, src, parity_req, ext_clk, timer_match,
    output rd_data, sioclk, bit_tick, sclk, parity_on, wakeup_on
  );

  modport host (
    output wr_en, wr_ch, wr_addr, wr_data, rd_ch, rd_addr,
    output mode, fmt, src, parity_req, ext_clk, timer_match,
    input  rd_data, sioclk, bit_tick, sclk, parity_on, wakeup_on
  );
endinterface

/* hw/sbrg_host.sv */
// shift logic end: keeps channel modes, forwards settings and clocks
`timescale 1ns/100ps
`include "sbrg_defines.svh"
module sbrg_host #(
  parameter int NCH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  sbrg_if.host                  lnk,
  input  wire logic             cfg_wr_i,
  input  wire logic             cfg_ch_i,
  input  wire logic [1:0]       cfg_addr_i,
  input  wire logic [7:0]       cfg_data_i,
  input  wire logic             cfg_rd_ch_i,
  input  wire logic [1:0]       cfg_rd_addr_i,
  output logic      [7:0]       cfg_rd_data_o,
  input  wire logic [NCH-1:0]   ext_clk_i,
  input  wire logic             timer_match_i,
  output logic      [NCH-1:0]   sioclk_o,
  output logic      [NCH-1:0]   bit_tick_o,
  output logic      [NCH-1:0]   sclk_o,
  output logic      [NCH-1:0]   parity_on_o,
  output logic      [NCH-1:0]   wakeup_on_o
);

  typedef struct packed {
    logic [NCH-1:0][7:0] mode_reg;
    logic                wr_en;
    logic                wr_ch;
    logic [1:0]          wr_addr;
    logic [7:0]          wr_data;
    logic                rd_ch;
    logic [1:0]          rd_addr;
    logic                rd_local;
    logic                rd_local_d;
    logic [7:0]          rd_mode;
    logic [7:0]          rd_data;
    logic [NCH-1:0]      ext_clk;
    logic                tmr;
    logic [NCH-1:0]      sioclk;
    logic [NCH-1:0]      bit_tick;
    logic [NCH-1:0]      sclk;
    logic [NCH-1:0]      par;
    logic [NCH-1:0]      wak;
  } sbrg_host_s;

  sbrg_host_s st_r;
  sbrg_host_s st_nxt;

  // ==========================================================
  // next state
  always_comb
  begin
    logic [3:0] n_code;
    logic       shift_ch;
    n_code   = cfg_data_i[`SBRG_DIV_MSB:`SBRG_DIV_LSB];
    shift_ch = st_r.mode_reg[cfg_ch_i][`SBRG_SHIFT_BIT];
    st_nxt   = st_r;
    // mode register is kept here, the other two go to the generator
    st_nxt.wr_en   = cfg_wr_i && (cfg_addr_i != `SBRG_ADDR_MODE);
    st_nxt.wr_ch   = cfg_ch_i;
    st_nxt.wr_addr = cfg_addr_i;
    st_nxt.wr_data = cfg_data_i;
    if (cfg_wr_i && cfg_addr_i == `SBRG_ADDR_MODE)
      st_nxt.mode_reg[cfg_ch_i] = cfg_data_i;
    // fraction enable is forced clear for N of 1 or 16 and in shift mode
    if (cfg_addr_i == `SBRG_ADDR_DIVCTL && (n_code <= 4'h1 || shift_ch))
      st_nxt.wr_data[`SBRG_FEN_BIT] = 1'b0;
    // read request: two stages here, one in the generator
    st_nxt.rd_ch      = cfg_rd_ch_i;
    st_nxt.rd_addr    = cfg_rd_addr_i;
    st_nxt.rd_local   = (cfg_rd_addr_i == `SBRG_ADDR_MODE);
    st_nxt.rd_local_d = st_r.rd_local;
    st_nxt.rd_mode    = st_r.mode_reg[st_r.rd_ch];
    st_nxt.rd_data    = st_r.rd_local_d ? st_r.rd_mode : lnk.rd_data;
    // clock sources forwarded; external rate is limited by the user side
    st_nxt.ext_clk  = ext_clk_i;
    st_nxt.tmr      = timer_match_i;
    st_nxt.sioclk   = lnk.sioclk;
    st_nxt.bit_tick = lnk.bit_tick;
    st_nxt.sclk     = lnk.sclk;
    st_nxt.par      = lnk.parity_on;
    st_nxt.wak      = lnk.wakeup_on;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r          <= '0;
      st_r.mode_reg <= {NCH{`SBRG_MODE_RST}};
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // link drive from state
  always_comb
  begin
    lnk.wr_en       = st_r.wr_en;
    lnk.wr_ch       = st_r.wr_ch;
    lnk.wr_addr     = st_r.wr_addr;
    lnk.wr_data     = st_r.wr_data;
    lnk.rd_ch       = st_r.rd_ch;
    lnk.rd_addr     = st_r.rd_addr;
    lnk.ext_clk     = st_r.ext_clk;
    lnk.timer_match = st_r.tmr;
    for (int c = 0; c < NCH; c++)
    begin
      lnk.mode[c]       = sbrg_pkg::sbrg_mode_e'(st_r.mode_reg[c][`SBRG_SHIFT_BIT]);
      lnk.fmt[c]        = sbrg_pkg::sbrg_fmt_e'(st_r.mode_reg[c][`SBRG_FMT_MSB:`SBRG_FMT_LSB]);
      lnk.src[c]        = sbrg_pkg::sbrg_src_e'(st_r.mode_reg[c][`SBRG_SRC_MSB:`SBRG_SRC_LSB]);
      lnk.parity_req[c] = st_r.mode_reg[c][`SBRG_PAR_BIT];
    end
  end

  assign cfg_rd_data_o = st_r.rd_data;
  assign sioclk_o      = st_r.sioclk;
  assign bit_tick_o    = st_r.bit_tick;
  assign sclk_o        = st_r.sclk;
  assign parity_on_o   = st_r.par;
  assign wakeup_on_o   = st_r.wak;

endmodule

/* bench/sbrg_properties.sv */
// concurrent checks on the link between the shift logic end and the generator end
`timescale 1ns/100ps
module sbrg_properties #(
  parameter int NCH = 2
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input sbrg_pkg::sbrg_mode_e [NCH-1:0] mode,
  input sbrg_pkg::sbrg_fmt_e [NCH-1:0]  fmt,
  input sbrg_pkg::sbrg_src_e [NCH-1:0]  src,
  input wire logic [NCH-1:0]            parity_req,
  input wire logic [NCH-1:0]            ext_clk,
  input wire logic                      timer_match,
  input wire logic [1:0]                rd_addr,
  input wire logic [7:0]                rd_data,
  input wire logic [NCH-1:0]            sioclk,
  input wire logic [NCH-1:0]            bit_tick,
  input wire logic [NCH-1:0]            sclk,
  input wire logic [NCH-1:0]            parity_on,
  input wire logic [NCH-1:0]            wakeup_on
);
  // ==========================================================
  // channel 0 held in one mode and source for four cycles
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence held(m, s);
    (mode[0] == m && src[0] == s)[*4];
  endsequence
  // ==========================================================
  // assertions on channel 0 and on unmapped reads
  a_parity_gate: assert property (
    $stable(fmt[0]) && $stable(parity_req[0]) && $stable(mode[0])
    |-> parity_on[0] == (parity_req[0] && mode[0] == sbrg_pkg::SBRG_MODE_UART &&
                         (fmt[0] == sbrg_pkg::SBRG_FMT_7B || fmt[0] == sbrg_pkg::SBRG_FMT_8B)))
    else $error("parity enable wrong for format");
  a_wakeup_9b: assert property (
    $stable(fmt[0]) && $stable(mode[0])
    |-> wakeup_on[0] == (mode[0] == sbrg_pkg::SBRG_MODE_UART && fmt[0] == sbrg_pkg::SBRG_FMT_9B))
    else $error("wake-up enable wrong for format");
  a_sclk_async_high: assert property (
    mode[0] == sbrg_pkg::SBRG_MODE_UART && $past(mode[0]) == sbrg_pkg::SBRG_MODE_UART
    |-> sclk[0])
    else $error("shift clock not high in async mode");
  a_fc2_rate: assert property (
    held(sbrg_pkg::SBRG_MODE_UART, sbrg_pkg::SBRG_SRC_FC2) ##0 sioclk[0]
    |-> ##1 !sioclk[0] ##1 (sioclk[0] || src[0] != sbrg_pkg::SBRG_SRC_FC2))
    else $error("half rate source not every second cycle");
  a_timer_source: assert property (
    held(sbrg_pkg::SBRG_MODE_UART, sbrg_pkg::SBRG_SRC_TMR) ##0 sioclk[0]
    |-> $past(timer_match) || $past(timer_match, 2))
    else $error("basic clock without timer match");
  a_ext_follow: assert property (
    held(sbrg_pkg::SBRG_MODE_SHIFT, sbrg_pkg::SBRG_SRC_EXT) ##0 $stable(ext_clk[0])
    |=> sclk[0] == $past(ext_clk[0]))
    else $error("shift clock does not follow external clock");
  a_shift_tick_rise: assert property (
    held(sbrg_pkg::SBRG_MODE_SHIFT, sbrg_pkg::SBRG_SRC_BRG) ##0 bit_tick[0]
    |-> ##[0:1] sclk[0])
    else $error("shift bit tick away from rising shift clock");
  a_rd_unmapped: assert property (
    rd_addr == 2'h3 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_sioclk_pulse: assert property (
    mode[0] == sbrg_pkg::SBRG_MODE_UART && src[0] != sbrg_pkg::SBRG_SRC_TMR && sioclk[0] &&
    $stable(mode[0]) && $stable(src[0])
    |=> !sioclk[0])
    else $error("basic clock pulse longer than one cycle");
endmodule

/* bench/tb_top.sv */
// self-checking bench driving the shift logic end joined to the generator end
`timescale 1ns/100ps
module tb_top;
  logic       clk_i;
  logic       rst_i;
  logic       cfg_wr, cfg_ch, rd_ch;
  logic [1:0] cfg_addr, rd_addr;
  logic [7:0] cfg_data, rd_data;
  logic [1:0] ext_clk = 2'h0;
  logic       tmr = 1'b0;
  logic [1:0] sio, tick, sclk, par_on, wake_on;
  int         bad_count, n_compared, ext_half, tmr_per, ecnt, i;
  logic [7:0] dtab [6] = '{8'h01, 8'h00, 8'h13, 8'h22, 8'h31, 8'h0F};
  int         ptab [6] = '{4, 64, 48, 128, 256, 60};

  sbrg_if #(.NCH(2)) lnk ();
  sbrg_host #(.NCH(2)) sbrg_host_i (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk),
    .cfg_wr_i(cfg_wr), .cfg_ch_i(cfg_ch), .cfg_addr_i(cfg_addr), .cfg_data_i(cfg_data),
    .cfg_rd_ch_i(rd_ch), .cfg_rd_addr_i(rd_addr), .cfg_rd_data_o(rd_data),
    .ext_clk_i(ext_clk), .timer_match_i(tmr), .sioclk_o(sio), .bit_tick_o(tick),
    .sclk_o(sclk), .parity_on_o(par_on), .wakeup_on_o(wake_on));
  sbrg_dev #(.NCH(2)) sbrg_dev_i (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk));
  sbrg_properties #(.NCH(2)) sbrg_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .mode(lnk.mode), .fmt(lnk.fmt), .src(lnk.src), .parity_req(lnk.parity_req),
    .ext_clk(lnk.ext_clk), .timer_match(lnk.timer_match), .rd_addr(lnk.rd_addr),
    .rd_data(lnk.rd_data), .sioclk(lnk.sioclk), .bit_tick(lnk.bit_tick),
    .sclk(lnk.sclk), .parity_on(lnk.parity_on), .wakeup_on(lnk.wakeup_on));

  // ==========================================================
  // clock, external serial clock and timer match makers
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
  begin
    ecnt = ecnt + 1;
    if (ext_half != 0 && ecnt % ext_half == 0)
      ext_clk[0] = ~ext_clk[0];
    tmr = (tmr_per != 0 && ecnt % tmr_per == 0);
  end

  // ==========================================================
  // compare, access and measuring tasks
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic ch, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cfg_wr = 1'b1;
    cfg_ch = ch;
    cfg_addr = a;
    cfg_data = d;
    @(negedge clk_i);
    cfg_wr = 1'b0;
  endtask
  // read answer lands two edges after the address is sampled
  task automatic rd(input logic ch, input logic [1:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    rd_ch = ch;
    rd_addr = a;
    repeat (4) @(negedge clk_i);
    chk(rd_data, exp);
  endtask
  // cycles between pulses, third interval so settings have settled
  task automatic per(input int ch, input int tk, input int exp);
    int n;
    int k;
    for (k = 0; k < 3; k++)
    begin
      n = 0;
      @(negedge clk_i);
      while ((tk ? tick[ch] : sio[ch]) !== 1'b1)
      begin
        @(negedge clk_i);
        n++;
        if (n > 5000)
        begin
          bad_count++;
          summarize();
        end
      end
    end
    chk(n + 1, exp);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    cfg_wr = 1'b0;
    cfg_ch = 1'b0;
    cfg_addr = 2'h0;
    cfg_data = 8'h00;
    rd_ch = 1'b0;
    rd_addr = 2'h0;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    for (i = 0; i < 8; i++)
      rd(i[2], i[1:0], 8'h00);
    wr(1'b0, 2'h1, 8'h08);
    for (i = 0; i < 6; i++)
    begin
      wr(1'b0, 2'h0, dtab[i]);
      per(0, 0, ptab[i]);
    end
    wr(1'b0, 2'h0, 8'h01);
    per(0, 1, 64);
    wr(1'b0, 2'h0, 8'h42);
    rd(1'b0, 2'h0, 8'h42);
    per(0, 1, 160);
    wr(1'b0, 2'h1, 8'h0F);
    per(0, 1, 132);
    wr(1'b0, 2'h1, 8'h00);
    per(0, 1, 128);
    wr(1'b0, 2'h0, 8'h41);
    rd(1'b0, 2'h0, 8'h01);
    wr(1'b0, 2'h0, 8'h40);
    rd(1'b0, 2'h0, 8'h00);
    wr(1'b0, 2'h2, 8'h10);
    wr(1'b0, 2'h0, 8'h42);
    rd(1'b0, 2'h0, 8'h02);
    per(0, 1, 16);
    chk(sclk[0], 1'b1);
    repeat (8) @(negedge clk_i);
    chk(sclk[0], 1'b0);
    tmr_per = 10;
    wr(1'b0, 2'h2, 8'h12);
    per(0, 1, 16);
    wr(1'b0, 2'h2, 8'h02);
    per(0, 0, 10);
    wr(1'b0, 2'h2, 8'h01);
    per(0, 0, 2);
    ext_half = 4;
    wr(1'b0, 2'h2, 8'h03);
    per(0, 0, 8);
    per(0, 1, 128);
    ext_half = 8;
    wr(1'b0, 2'h2, 8'h13);
    per(0, 1, 16);
    ext_half = 0;
    for (i = 0; i < 3; i++)
    begin
      wr(1'b0, 2'h2, 8'(8'h20 | (i << 2)));
      rd(1'b0, 2'h2, 8'(8'h20 | (i << 2)));
      chk(par_on[0], i != 2);
      chk(wake_on[0], i == 2);
    end
    wr(1'b0, 2'h2, 8'h00);
    wr(1'b0, 2'h0, 8'h01);
    wr(1'b1, 2'h0, 8'h02);
    per(1, 0, 8);
    per(0, 0, 4);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rd(1'b1, 2'h0, 8'h00);
    summarize();
  end
endmodule
